// >>> hw/oscillator_manual_enable.v
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ome_defs.vh"
// Operation
// - Bit 7 forces external oscillator on in its configured mode.
// - Clear bit withdraws only the manual request; other requesters still enable.
// - Bit 6 forces high-frequency internal oscillator on at selected frequency.
// - Bit 5 forces medium-frequency internal oscillator on regardless of others.
module ome_oscillator_manual_enable
(
  input wire mclk,
  input wire rst_n,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_osc_req,
  input wire high_freq_int_osc_req,
  input wire mid_freq_int_osc_req,
  input wire low_freq_int_osc_req,
  input wire secondary_osc_req,
  input wire converter_rc_osc_req,
  output wire external_oscillator_en,
  output wire high_freq_internal_oscillator_en,
  output wire mid_freq_internal_oscillator_en,
  output wire low_freq_internal_oscillator_en,
  output wire secondary_osc_en,
  output wire converter_rc_osc_en,
  output reg [2:0] ext_osc_mode_config,
  output reg [2:0] internal_osc_freq_select,
  output reg secondary_osc_power_setting
);

  reg [7:0] force_r;
  reg [7:0] cfg_r;
  reg aw_held_r;
  reg w_held_r;
  reg [3:0] awaddr_r;
  reg [7:0] wdata_r;
  reg wstrb0_r;
  wire [5:0] other_req;
  wire [5:0] osc_en;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire [3:0] wr_addr;
  wire [7:0] wr_data;
  wire wr_lane;

  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? wdata_r : s_axi_wdata[7:0];
  assign wr_lane = w_held_r ? wstrb0_r : s_axi_wstrb[0];
  assign do_write = (aw_held_r | aw_take) & (w_held_r | w_take) & ~s_axi_bvalid;

  // Address decode
  function is_mapped;
    input [3:0] a;
    begin
      if (a == `OME_FORCE_ADDR)
        is_mapped = 1'b1;
      else if (a == `OME_CFG_ADDR)
        is_mapped = 1'b1;
      else
        is_mapped = 1'b0;
    end
  endfunction

  // Write channel handshake
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `OME_RESP_OKAY;
    end
    else
    begin
      if (do_write)
      begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? `OME_RESP_OKAY : `OME_RESP_SLVERR;
      end
      else
      begin
        if (aw_take)
        begin
          aw_held_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end
        if (w_take)
        begin
          w_held_r <= 1'b1;
          wdata_r <= s_axi_wdata[7:0];
          wstrb0_r <= s_axi_wstrb[0];
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid & s_axi_bready)
        begin
          s_axi_bvalid <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // Register storage
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      force_r <= `OME_FORCE_RST;
      cfg_r <= `OME_CFG_RST;
    end
    else if (do_write & wr_lane)
    begin
      if (wr_addr == `OME_FORCE_ADDR)
        force_r <= wr_data & `OME_FORCE_MASK;
      else if (wr_addr == `OME_CFG_ADDR)
        cfg_r <= wr_data & `OME_CFG_MASK;
    end
  end

  // Read channel
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `OME_RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `OME_FORCE_ADDR)
      begin
        s_axi_rdata <= {24'h000000, force_r};
        s_axi_rresp <= `OME_RESP_OKAY;
      end
      else if (s_axi_araddr == `OME_CFG_ADDR)
      begin
        s_axi_rdata <= {24'h000000, cfg_r};
        s_axi_rresp <= `OME_RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `OME_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Operating mode outputs
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_osc_mode_config <= 3'h0;
      internal_osc_freq_select <= 3'h0;
      secondary_osc_power_setting <= 1'b0;
    end
    else
    begin
      ext_osc_mode_config <= cfg_r[`OME_CFG_EXT_MSB:`OME_CFG_EXT_LSB];
      internal_osc_freq_select <= cfg_r[`OME_CFG_HF_MSB:`OME_CFG_HF_LSB];
      secondary_osc_power_setting <= cfg_r[`OME_CFG_SEC_BIT];
    end
  end

  assign other_req = {ext_osc_req, high_freq_int_osc_req, mid_freq_int_osc_req,
    low_freq_int_osc_req, secondary_osc_req, converter_rc_osc_req};

  ome_osc_gate u_gate
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .force_on(force_r),
    .other_req(other_req),
    .osc_enable(osc_en)
  );

  assign external_oscillator_en = osc_en[5];
  assign high_freq_internal_oscillator_en = osc_en[4];
  assign mid_freq_internal_oscillator_en = osc_en[3];
  assign low_freq_internal_oscillator_en = osc_en[2];
  assign secondary_osc_en = osc_en[1];
  assign converter_rc_osc_en = osc_en[0];

endmodule

// >>> hw/ome_defs.vh
`ifndef OME_DEFS_VH
`define OME_DEFS_VH
`define OME_ADDR_W 4
`define OME_FORCE_ADDR 4'h0
`define OME_CFG_ADDR 4'h4
`define OME_FORCE_RST 8'h00
`define OME_FORCE_MASK 8'hfc
`define OME_CFG_RST 8'h00
`define OME_BIT_EXT 7
`define OME_BIT_HF 6
`define OME_BIT_MF 5
`define OME_BIT_LF 4
`define OME_BIT_SEC 3
`define OME_BIT_ADC 2
`define OME_CFG_EXT_LSB 0
`define OME_CFG_EXT_MSB 2
`define OME_CFG_HF_LSB 3
`define OME_CFG_HF_MSB 5
`define OME_CFG_SEC_BIT 6
`define OME_CFG_MASK 8'h7f
`define OME_RESP_OKAY 2'b00
`define OME_RESP_SLVERR 2'b10
`endif

// >>> hw/ome_osc_gate.v
`timescale 1ns/10ps
`include "ome_defs.vh"
// Merges manual forces with other requesters into oscillator enables
module ome_osc_gate
(
  input wire mclk,
  input wire rst_n,
  input wire [7:0] force_on,
  input wire [5:0] other_req,
  output reg [5:0] osc_enable
);

  wire [5:0] force_bits;

  assign force_bits = force_on[7:2];

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      osc_enable <= 6'h00;
    else
      osc_enable <= force_bits | other_req;
  end

endmodule

// >>> verif/ome_monitor.sv
`timescale 1ns/10ps
module ome_monitor
(
  input wire mclk,
  input wire rst_n,
  input wire ext_osc_req,
  input wire high_freq_int_osc_req,
  input wire mid_freq_int_osc_req,
  input wire low_freq_int_osc_req,
  input wire secondary_osc_req,
  input wire converter_rc_osc_req,
  input wire external_oscillator_en,
  input wire high_freq_internal_oscillator_en,
  input wire mid_freq_internal_oscillator_en,
  input wire low_freq_internal_oscillator_en,
  input wire secondary_osc_en,
  input wire converter_rc_osc_en,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ext_req_a: assert property (ext_osc_req |=> external_oscillator_en)
    else $error("ext enable missing");
  hf_req_a: assert property (high_freq_int_osc_req |=> high_freq_internal_oscillator_en)
    else $error("hf enable missing");
  mf_req_a: assert property (mid_freq_int_osc_req |=> mid_freq_internal_oscillator_en)
    else $error("mf enable missing");
  sec_req_a: assert property (secondary_osc_req |=> secondary_osc_en)
    else $error("sec enable missing");
  lf_req_a: assert property (low_freq_int_osc_req |=> low_freq_internal_oscillator_en)
    else $error("lf enable missing");
  conv_req_a: assert property (converter_rc_osc_req |=> converter_rc_osc_en)
    else $error("conv enable missing");
  rd_pad_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0
    |=> s_axi_rvalid && s_axi_rdata[1:0] == 2'h0 && s_axi_rdata[31:8] == 24'h0)
    else $error("low bits not zero");
  ext_drop_a: assert property ($fell(external_oscillator_en) |-> !$past(ext_osc_req))
    else $error("ext dropped while requested");
  cover property ($rose(external_oscillator_en));
  cover property ($rose(secondary_osc_en));
  cover property (s_axi_rvalid);
endmodule
bind ome_oscillator_manual_enable ome_monitor u_mon (.*);

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
  reg mclk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg s_axi_arvalid = 0, s_axi_rready = 0;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [5:0] req = 6'h0;
  wire ext_osc_req, high_freq_int_osc_req, mid_freq_int_osc_req, low_freq_int_osc_req;
  wire secondary_osc_req, converter_rc_osc_req;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire external_oscillator_en, high_freq_internal_oscillator_en, secondary_osc_en;
  wire mid_freq_internal_oscillator_en, low_freq_internal_oscillator_en, converter_rc_osc_en;
  wire [2:0] ext_osc_mode_config, internal_osc_freq_select;
  wire secondary_osc_power_setting;
  wire [5:0] en = {external_oscillator_en, high_freq_internal_oscillator_en,
    mid_freq_internal_oscillator_en, low_freq_internal_oscillator_en, secondary_osc_en,
    converter_rc_osc_en};
  integer fails = 0, tests_run = 0, i, k;
  assign {ext_osc_req, high_freq_int_osc_req, mid_freq_int_osc_req, low_freq_int_osc_req,
    secondary_osc_req, converter_rc_osc_req} = req;
  ome_oscillator_manual_enable dut (.*);
  always #2 mclk = ~mclk;
  task print_verdict;
  begin
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input [39:0] n, input [31:0] e, input [31:0] g);
  begin
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      $display("Error %s exp %h got %h", n, e, g);
      fails = fails + 1;
    end
  end
  endtask
  task tmo;
  begin
    if (i >= 99)
    begin
      fails = fails + 1;
      print_verdict;
    end
  end
  endtask
  task wr(input [3:0] a, input [31:0] d, input [1:0] r);
  begin
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 99 && !s_axi_bvalid; i = i + 1)
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    tmo;
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  end
  endtask
  task rd(input [3:0] a, input [31:0] d, input [1:0] r);
  begin
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 99 && !s_axi_rvalid; i = i + 1)
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    tmo;
    s_axi_rready <= 1'b0;
    chk("rdata", d, s_axi_rdata);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  end
  endtask
  initial
  begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h0, 32'hffffffff, 2'h0);
    rd(4'h0, 32'hfc, 2'h0);
    wr(4'h4, 32'hff, 2'h0);
    repeat (2) @(posedge mclk);
    chk("cfg", 32'h7f, {25'h0, secondary_osc_power_setting, internal_osc_freq_select, ext_osc_mode_config});
    chk("en", 32'h3f, {26'h0, en});
    rd(4'h4, 32'h7f, 2'h0);
    for (k = 0; k < 6; k = k + 1)
    begin
      wr(4'h0, 32'h4 << k, 2'h0);
      repeat (2) @(posedge mclk);
      chk("en", 32'h1 << k, {26'h0, en});
    end
    wr(4'h0, 32'h0, 2'h0);
    req <= 6'h3f;
    repeat (2) @(posedge mclk);
    chk("en", 32'h3f, {26'h0, en});
    req <= 6'h0;
    repeat (2) @(posedge mclk);
    chk("en", 32'h0, {26'h0, en});
    s_axi_wstrb <= 4'h0;
    wr(4'h0, 32'hff, 2'h0);
    s_axi_wstrb <= 4'hf;
    wr(4'h8, 32'hff, 2'h2);
    rd(4'h8, 32'h0, 2'h2);
    rd(4'h0, 32'h0, 2'h0);
    wr(4'h0, 32'hff, 2'h0);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 32'h0, 2'h0);
    print_verdict;
  end
endmodule
